// ### fcdp_defs.vh
// fcdp_defs.vh: offsets, field positions, reset values and timing counts
// assumes 32-bit classic wishbone with byte addresses, registers in the low byte except the command/address register (bits 31, 30 and 17:0)
`ifndef FCDP_DEFS_VH
`define FCDP_DEFS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FCDP_OFF_CLKDIV     4'h0
`define FCDP_OFF_PROT       4'h4
`define FCDP_OFF_CMD_ADDR   4'h8
`define FCDP_OFF_STATUS     4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCDP_DIV_LOCK_BIT   6
`define FCDP_OPEN_BIT       7
`define FCDP_HDIS_BIT       5
`define FCDP_HSIZE_HI       4
`define FCDP_HSIZE_LO       3
`define FCDP_LDIS_BIT       2
`define FCDP_LSIZE_HI       1
`define FCDP_LSIZE_LO       0
`define FCDP_CMD_ERASE_BIT  31
`define FCDP_CMD_GO_BIT     30
`define FCDP_ST_VIOL_BIT    0
`define FCDP_ST_DONE_BIT    1
`define FCDP_ST_BUSY_BIT    2

// ----------------------------------------------------------------
// reset values and fixed addresses
// ----------------------------------------------------------------
`define FCDP_CLKDIV_RST     8'h00
`define FCDP_PROT_RST       8'hff
`define FCDP_PROT_LOAD_ADDR 18'h3ff0c
`define FCDP_LOW_BASE       18'h38000
`define FCDP_HIGH_END       18'h3ffff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FCDP_TICK_HZ        1000000
`define FCDP_PROG_US        16'h0014
`define FCDP_ERASE_US       16'h0064

`endif

// ### fcdp_tick_gen.v
// fcdp_tick_gen.v: divides the bus clock down to a 1 MHz tick
// assumes divider_value was chosen from the recommended band table
`timescale 1ns/1ps

module fcdp_tick_gen
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [5:0] divider_value_i,
    output reg        tick_o
);

reg [5:0] cnt_ff;
wire [5:0] nxt_cnt;

// divide by value plus one: code 0x00 covers the 1.0 to 1.6 MHz band
assign nxt_cnt = (cnt_ff >= divider_value_i) ? 6'h00 : cnt_ff + 6'h01;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        cnt_ff <= 6'h00;
        tick_o <= 1'b0;
    end
    else
    begin
        cnt_ff <= nxt_cnt;
        tick_o <= (cnt_ff >= divider_value_i);
    end
end

endmodule // fcdp_tick_gen

// ### fcdp_range_check.v
// fcdp_range_check.v: classes one flash address as protected or not
// assumes an 18-bit global address and the protection byte layout
`timescale 1ns/1ps
`include "fcdp_defs.vh"

module fcdp_range_check
(
    input  wire [17:0] addr_i,
    input  wire [7:0]  prot_i,
    output wire        protected_o
);

// ----------------------------------------------------------------
// range bounds
// ----------------------------------------------------------------
function [17:0] high_start;
    input [1:0] size;
    begin
        case (size)
            2'b00:   high_start = 18'h3f800;
            2'b01:   high_start = 18'h3f000;
            2'b10:   high_start = 18'h3e000;
            default: high_start = 18'h3c000;
        endcase
    end
endfunction

function [17:0] low_end;
    input [1:0] size;
    begin
        case (size)
            2'b00:   low_end = 18'h383ff;
            2'b01:   low_end = 18'h387ff;
            2'b10:   low_end = 18'h38fff;
            default: low_end = 18'h39fff;
        endcase
    end
endfunction

wire in_high;
wire in_low;
wire in_any;

assign in_high = !prot_i[`FCDP_HDIS_BIT]
    && (addr_i >= high_start(prot_i[`FCDP_HSIZE_HI:`FCDP_HSIZE_LO]))
    && (addr_i <= `FCDP_HIGH_END);
assign in_low = !prot_i[`FCDP_LDIS_BIT]
    && (addr_i >= `FCDP_LOW_BASE)
    && (addr_i <= low_end(prot_i[`FCDP_LSIZE_HI:`FCDP_LSIZE_LO]));
assign in_any = in_high | in_low;

// open mode protects inside the ranges, closed mode protects outside them
assign protected_o = prot_i[`FCDP_OPEN_BIT] ? in_any : !in_any;

endmodule // fcdp_range_check

// ### fcdp_ctrl.v
// fcdp_ctrl.v: flash clock divider and range protection controller
// assumes a classic wishbone master on clk_i and a flash word reader for
// the boot-time protection load; program and erase are timed, not driven
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "fcdp_defs.vh"

module fcdp_ctrl
#(
    parameter CLK_HZ = 100000000
)
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    output reg         nvm_rd_o,
    output reg  [17:0] nvm_addr_o,
    input  wire        nvm_valid_i,
    input  wire [7:0]  nvm_data_i,
    output reg         tick_o,
    output reg         prog_busy_o
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
localparam ST_LOAD = 3'b001;
localparam ST_IDLE = 3'b010;
localparam ST_RUN  = 3'b100;

localparam [15:0] PROG_TICKS  = `FCDP_PROG_US;
localparam [15:0] ERASE_TICKS = `FCDP_ERASE_US;

reg [2:0]  state_ff;
reg [2:0]  nxt_state;
reg [7:0]  clkdiv_ff;
reg [7:0]  nxt_clkdiv;
reg [7:0]  prot_ff;
reg [7:0]  nxt_prot;
reg [17:0] cmd_addr_ff;
reg [17:0] nxt_cmd_addr;
reg        erase_ff;
reg        nxt_erase;
reg        viol_ff;
reg        nxt_viol;
reg        done_ff;
reg        nxt_done;
reg [15:0] ticks_ff;
reg [15:0] nxt_ticks;

wire       tick_w;
wire       cmd_prot_w;
wire       wb_req;
wire       wb_wr;
wire       mapped;
wire       go_req;

// ----------------------------------------------------------------
// submodules
// ----------------------------------------------------------------
fcdp_tick_gen fcdp_tick_gen_i
(
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .divider_value_i (clkdiv_ff[5:0]),
    .tick_o          (tick_w)
);

fcdp_range_check fcdp_range_check_i
(
    .addr_i      (cmd_addr_ff),
    .prot_i      (prot_ff),
    .protected_o (cmd_prot_w)
);

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
// answer one cycle after the strobe, dropped in the cycle after
assign wb_req = cyc_i && stb_i && !ack_o && !err_o;
assign mapped = (adr_i == `FCDP_OFF_CLKDIV) || (adr_i == `FCDP_OFF_PROT)
             || (adr_i == `FCDP_OFF_CMD_ADDR) || (adr_i == `FCDP_OFF_STATUS);
assign wb_wr  = wb_req && we_i && mapped;
assign go_req = wb_wr && (adr_i == `FCDP_OFF_CMD_ADDR) && sel_i[3]
             && dat_i[`FCDP_CMD_GO_BIT];

// ----------------------------------------------------------------
// next state
// ----------------------------------------------------------------
always @*
begin
    nxt_state    = state_ff;
    nxt_clkdiv   = clkdiv_ff;
    nxt_prot     = prot_ff;
    nxt_cmd_addr = cmd_addr_ff;
    nxt_erase    = erase_ff;
    nxt_viol     = viol_ff;
    nxt_done     = done_ff;
    nxt_ticks    = ticks_ff;

    if (wb_wr && sel_i[0] && (adr_i == `FCDP_OFF_CLKDIV))
    begin
        if (!clkdiv_ff[`FCDP_DIV_LOCK_BIT])
            nxt_clkdiv[5:0] = dat_i[5:0];
        // lock is set-only: a written zero leaves it alone
        nxt_clkdiv[`FCDP_DIV_LOCK_BIT] = clkdiv_ff[`FCDP_DIV_LOCK_BIT]
                                       | dat_i[`FCDP_DIV_LOCK_BIT];
    end

    if (wb_wr && sel_i[0] && (adr_i == `FCDP_OFF_PROT) && !state_ff[0])
    begin
        nxt_prot[7:2] = dat_i[7:2];
        if (prot_ff[`FCDP_LDIS_BIT])
            nxt_prot[1:0] = dat_i[1:0];
    end

    // write one to clear; a new event in the same cycle wins
    if (wb_wr && sel_i[0] && (adr_i == `FCDP_OFF_STATUS))
    begin
        if (dat_i[`FCDP_ST_VIOL_BIT])
            nxt_viol = 1'b0;
        if (dat_i[`FCDP_ST_DONE_BIT])
            nxt_done = 1'b0;
    end

    if (wb_wr && (adr_i == `FCDP_OFF_CMD_ADDR) && !state_ff[2])
    begin
        if (sel_i[0])
            nxt_cmd_addr[7:0] = dat_i[7:0];
        if (sel_i[1])
            nxt_cmd_addr[15:8] = dat_i[15:8];
        if (sel_i[2])
            nxt_cmd_addr[17:16] = dat_i[17:16];
        if (sel_i[3])
            nxt_erase = dat_i[`FCDP_CMD_ERASE_BIT];
    end

    case (state_ff)
        ST_LOAD:
        begin
            if (nvm_valid_i)
            begin
                nxt_prot  = nvm_data_i;
                nxt_state = ST_IDLE;
            end
        end
        ST_IDLE:
        begin
            // checked against the address already held, before this write
            if (go_req)
            begin
                if (cmd_prot_w)
                    nxt_viol = 1'b1;
                else
                begin
                    nxt_ticks = dat_i[`FCDP_CMD_ERASE_BIT] ? ERASE_TICKS : PROG_TICKS;
                    nxt_state = ST_RUN;
                end
            end
        end
        ST_RUN:
        begin
            if (tick_w)
            begin
                if (ticks_ff == 16'h0001)
                begin
                    nxt_done  = 1'b1;
                    nxt_state = ST_IDLE;
                end
                nxt_ticks = ticks_ff - 16'h0001;
            end
        end
        default:
            nxt_state = ST_LOAD;
    endcase
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        state_ff    <= ST_LOAD;
        clkdiv_ff   <= `FCDP_CLKDIV_RST;
        prot_ff     <= `FCDP_PROT_RST;
        cmd_addr_ff <= 18'h00000;
        erase_ff    <= 1'b0;
        viol_ff     <= 1'b0;
        done_ff     <= 1'b0;
        ticks_ff    <= 16'h0000;
        ack_o       <= 1'b0;
        err_o       <= 1'b0;
        dat_o       <= 32'h00000000;
        nvm_rd_o    <= 1'b0;
        nvm_addr_o  <= 18'h00000;
        tick_o      <= 1'b0;
        prog_busy_o <= 1'b0;
    end
    else
    begin
        state_ff    <= nxt_state;
        clkdiv_ff   <= nxt_clkdiv;
        prot_ff     <= nxt_prot;
        cmd_addr_ff <= nxt_cmd_addr;
        erase_ff    <= nxt_erase;
        viol_ff     <= nxt_viol;
        done_ff     <= nxt_done;
        ticks_ff    <= nxt_ticks;
        ack_o       <= wb_req && mapped;
        err_o       <= wb_req && !mapped;
        nvm_rd_o    <= (nxt_state == ST_LOAD);
        nvm_addr_o  <= `FCDP_PROT_LOAD_ADDR;
        tick_o      <= tick_w;
        prog_busy_o <= (nxt_state == ST_RUN);
        dat_o       <= 32'h00000000;
        if (wb_req && !we_i)
        begin
            case (adr_i)
                `FCDP_OFF_CLKDIV:   dat_o <= {24'h000000, clkdiv_ff};
                `FCDP_OFF_PROT:     dat_o <= {24'h000000, prot_ff};
                `FCDP_OFF_CMD_ADDR: dat_o <= {erase_ff, 13'h0000, cmd_addr_ff};
                `FCDP_OFF_STATUS:   dat_o <= {29'h00000000, state_ff[2], done_ff, viol_ff};
                default:            dat_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule // fcdp_ctrl

// ### fcdp_ctrl_sva.sv
// fcdp_ctrl_sva.sv: port checks for the divider and protection controller
// assumes classic wishbone on clk_i and the boot load handshake of fcdp_ctrl
`timescale 1ns/1ps

module fcdp_ctrl_sva
(
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [3:0]  adr_i,
    input logic [3:0]  sel_i,
    input logic [31:0] dat_i,
    input logic [31:0] dat_o,
    input logic        ack_o,
    input logic        err_o,
    input logic        nvm_rd_o,
    input logic [17:0] nvm_addr_o,
    input logic        nvm_valid_i,
    input logic [7:0]  nvm_data_i,
    input logic        tick_o,
    input logic        prog_busy_o
);
    // ----------------------------------------------------------------
    // helper: lock seen on the bus, sticky until reset
    // ----------------------------------------------------------------
    logic req;
    logic locked_ff;
    logic nxt_locked;
    logic rd_div_ff;
    assign req        = cyc_i && stb_i && !ack_o && !err_o;
    assign nxt_locked = locked_ff || (req && we_i && adr_i == 4'h0 && sel_i[0] && dat_i[6]);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            locked_ff <= 1'b0;
            rd_div_ff <= 1'b0;
        end
        else
        begin
            locked_ff <= nxt_locked;
            // a divider read taken this edge is answered next cycle
            rd_div_ff <= req && !we_i && adr_i == 4'h0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_once:  assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_ack_take:  assert property (req && adr_i[1:0] == 2'b00 |=> ack_o && !err_o)
        else $error("mapped access not acked next cycle");
    chk_err_unmap: assert property (req && adr_i[1:0] != 2'b00 |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    chk_idle_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
        else $error("answer without request");
    chk_dat_zero:  assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    chk_load_addr: assert property (nvm_rd_o |-> nvm_addr_o == 18'h3ff0c)
        else $error("boot load from wrong address");
    chk_load_hold: assert property (nvm_rd_o && !nvm_valid_i |=> nvm_rd_o)
        else $error("boot load dropped early");
    chk_load_end:  assert property (nvm_rd_o && nvm_valid_i |=> !nvm_rd_o)
        else $error("boot load not finished");
    chk_lock_sticky: assert property (ack_o && rd_div_ff && locked_ff |-> dat_o[6])
        else $error("divider lock lost");
    chk_busy_long: assert property ($rose(prog_busy_o) |=> prog_busy_o [*8])
        else $error("timed operation too short");
endmodule // fcdp_ctrl_sva

bind fcdp_ctrl fcdp_ctrl_sva fcdp_ctrl_sva_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .nvm_rd_o, .nvm_addr_o, .nvm_valid_i,
    .nvm_data_i, .tick_o, .prog_busy_o);

// ### fcdp_ctrl_tb.sv
// fcdp_ctrl_tb.sv: register level test of the divider and protection controller
// assumes wishbone answers within the watchdog time and a bound port checker
`timescale 1ns/1ps
`include "fcdp_defs.vh"

module fcdp_ctrl_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, nvm_valid_i;
    logic [3:0]  adr_i, sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [7:0]  nvm_data_i;
    logic        ack_o, err_o, nvm_rd_o, tick_o, prog_busy_o, e;
    logic [17:0] nvm_addr_o;
    int          err_count, n_tests, n, i;
    time         t0;
    // every entry keeps the size of the entry before it when low range was enabled
    logic [7:0]  tp [18] = '{8'h87, 8'h87, 8'h83, 8'h83, 8'h8b, 8'h93, 8'h9b, 8'h23, 8'h23,
                             8'h27, 8'ha7, 8'ha6, 8'h82, 8'h86, 8'h81, 8'h81, 8'h85, 8'h80};
    logic [17:0] ta [18] = '{18'h3ffff, 18'h38000, 18'h39fff, 18'h3a000, 18'h3f000, 18'h3dfff,
                             18'h3c000, 18'h39fff, 18'h3a000, 18'h38000, 18'h3ffff, 18'h38fff,
                             18'h38fff, 18'h38fff, 18'h387ff, 18'h38800, 18'h38800, 18'h383ff};
    logic [17:0] tv = 18'h25355;

    fcdp_ctrl fcdp_ctrl_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .err_o, .nvm_rd_o, .nvm_addr_o, .nvm_valid_i, .nvm_data_i, .tick_o,
        .prog_busy_o);

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask

    // no fixed answer time assumed; the watchdog ends a wait that never returns
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1 && err_o !== 1'b1);
        q = dat_o;
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] x, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 43'h0};
        {nvm_valid_i, nvm_data_i, err_count, n_tests} = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("load request", 32'h1, {31'h0, nvm_rd_o});
        chk("load address", 32'h3ff0c, {14'h0, nvm_addr_o});
        nvm_valid_i <= 1'b1;
        nvm_data_i  <= 8'h2c;
        @(posedge clk_i);
        nvm_valid_i <= 1'b0;
        nvm_data_i  <= 8'h00;
        rdc(`FCDP_OFF_PROT, 32'h2c, "loaded protection");
        rdc(`FCDP_OFF_CLKDIV, 32'h0, "divider reset");
        wb(1'b1, `FCDP_OFF_CLKDIV, 32'h05);
        rdc(`FCDP_OFF_CLKDIV, 32'h05, "divider open");
        wb(1'b1, `FCDP_OFF_CLKDIV, 32'h45);
        wb(1'b1, `FCDP_OFF_CLKDIV, 32'h03);
        rdc(`FCDP_OFF_CLKDIV, 32'h45, "divider locked");
        @(posedge tick_o);
        t0 = $time;
        @(posedge tick_o);
        chk("tick period", 32'h3c, 32'($time - t0));
        wb(1'b1, 4'h2, 32'hff);
        chk("unmapped refused", 32'h1, {31'h0, e});
        wb(1'b1, `FCDP_OFF_PROT, 32'h03);
        wb(1'b1, `FCDP_OFF_PROT, 32'h00);
        rdc(`FCDP_OFF_PROT, 32'h03, "low size guarded");
        for (i = 0; i < 18; i++)
        begin
            wb(1'b1, `FCDP_OFF_PROT, {24'h0, tp[i]});
            rdc(`FCDP_OFF_PROT, {24'h0, tp[i]}, "protection");
            wb(1'b1, `FCDP_OFF_CMD_ADDR, {14'h0, ta[i]});
            wb(1'b1, `FCDP_OFF_CMD_ADDR, {i == 1, 1'b1, 12'h0, ta[i]});
            chk("busy", {31'h0, !tv[i]}, {31'h0, prog_busy_o});
            n = 0;
            do
                wb(1'b0, `FCDP_OFF_STATUS, 32'h0);
            while (q[2] !== 1'b0 && ++n < 400);
            chk("status", tv[i] ? 32'h1 : 32'h2, q);
            wb(1'b1, `FCDP_OFF_STATUS, 32'h3);
        end
        // mid-run reset: only reset may release the divider lock
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`FCDP_OFF_CLKDIV, {24'h0, `FCDP_CLKDIV_RST}, "divider after reset");
        rdc(`FCDP_OFF_PROT, {24'h0, `FCDP_PROT_RST}, "protection before load");
        wb(1'b1, `FCDP_OFF_CLKDIV, 32'h07);
        rdc(`FCDP_OFF_CLKDIV, 32'h07, "divider reopened");
        complete_run();
    end

    initial
    begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule // fcdp_ctrl_tb
